// ===== rtl/dsa_defines.vh
// Constants for the dual-slope converter sequencer.
// Assumes inclusion by bare name from the design files.
`ifndef DSA_DEFINES_VH
`define DSA_DEFINES_VH
`define DSA_OSC_DIV        4
`define DSA_DIV_W          2
`define DSA_INT_COUNTS     1000
`define DSA_DEINT_MAX      2000
`define DSA_CONV_COUNTS    4000
`define DSA_AZ_MIN         1000
`define DSA_CNT_W          12
`define DSA_PH_W           2
`define DSA_PH_AZ          2'h0
`define DSA_PH_INT         2'h1
`define DSA_PH_DEINT       2'h2
`define DSA_SEG_ALL        7'h7f
`define DSA_SEG_OFF        7'h00
`endif

// ===== rtl/dsa_seg_dec.v
// Seven-segment decoder for one decimal digit, segments {g,f,e,d,c,b,a}.
// Assumes a BCD input; codes above nine show blank.
`timescale 1ns/1ns
`include "dsa_defines.vh"
module dsa_seg_dec (
   // Digit in.
   input  wire [3:0] digit,
   // Segment drive, active high.
   output reg  [6:0] seg
);
   // Plain lookup table of the ten digit patterns.
   always @* begin
      case (digit)
         4'h0: seg = 7'h3f;
         4'h1: seg = 7'h06;
         4'h2: seg = 7'h5b;
         4'h3: seg = 7'h4f;
         4'h4: seg = 7'h66;
         4'h5: seg = 7'h6d;
         4'h6: seg = 7'h7d;
         4'h7: seg = 7'h07;
         4'h8: seg = 7'h7f;
         4'h9: seg = 7'h6f;
         default: seg = `DSA_SEG_OFF;
      endcase
   end
endmodule

// ===== rtl/dsa_seq.v
// Dual-slope converter sequencer: phase control, switch drive, result
// counting and seven-segment display drive.
// Assumes the analog front end, comparator and battery detector outside;
// their signals arrive asynchronously and are synchronised here.
`timescale 1ns/1ns
`include "dsa_defines.vh"
// Behaviour
// - Phases repeat in order auto-zero, integrate, de-integrate, auto-zero.
// - Auto-zero ties both analog inputs to analog common.
// - Auto-zero charges reference capacitor and closes offset loop.
// - Integration connects input for exactly 1000 counts.
// - Comparator sampled at integration end stores polarity for de-integration.
// - De-integration ties low input to common, high across oriented reference.
// - Counts from de-integration start to zero crossing form the result.
// - Test input lights all digit segments and minus sign, showing -1888.
// - Hold input freezes the display latch.
// - Three full digits; thousands is one output, lit for a leading one.
// - Low-battery segment follows detected battery-low condition.
// - Count clock is the oscillator divided by four.
// - Conversion totals 4000 counts; phase lengths within stated bounds.
// - Unused de-integration counts extend the following auto-zero.
// - Status outputs are high only in integration and de-integration.
module dsa_seq #(
   parameter INT_COUNTS  = `DSA_INT_COUNTS,
   parameter DEINT_MAX   = `DSA_DEINT_MAX,
   parameter CONV_COUNTS = `DSA_CONV_COUNTS
) (
   // Clock and reset.
   input  wire        ref_clk,
   input  wire        arst_n,
   // Asynchronous inputs from the analog side and the user.
   input  wire        comp_in,
   input  wire        batt_low_in,
   input  wire        test_in,
   input  wire        hold_in,
   // Analog switch controls.
   output reg         sw_in_to_com,
   output reg         sw_ref_charge,
   output reg         sw_az_loop,
   output reg         sw_in_connect,
   output reg         sw_lo_to_com,
   output reg         sw_ref_pos,
   output reg         sw_ref_neg,
   // Phase status and count pulse.
   output reg         integ_status_out,
   output reg         deint_status_out,
   output reg         count_tick,
   // Display segments {g,f,e,d,c,b,a}.
   output reg  [6:0]  units_seg,
   output reg  [6:0]  tens_seg,
   output reg  [6:0]  hundreds_seg,
   output reg         thousands_bc_seg,
   output reg         minus_sign_seg,
   output reg         low_batt_seg
);
   localparam CW = `DSA_CNT_W;
   // Count end points are worked out at full width, then cut on purpose.
   localparam [31:0] INT_LAST_W  = INT_COUNTS - 1;
   localparam [31:0] DEI_LAST_W  = DEINT_MAX - 1;
   localparam [31:0] CONV_LAST_W = CONV_COUNTS - 1;
   localparam [31:0] AZ_START_W  = INT_COUNTS;
   localparam [31:0] DIV_LAST_W  = `DSA_OSC_DIV - 1;
   localparam [CW-1:0] INT_LAST  = INT_LAST_W[CW-1:0];
   localparam [CW-1:0] DEI_LAST  = DEI_LAST_W[CW-1:0];
   localparam [CW-1:0] CONV_LAST = CONV_LAST_W[CW-1:0];
   // The first auto-zero after reset has no de-integration before it, so
   // it starts where the longest legal auto-zero would start.
   localparam [CW-1:0] AZ_START  = AZ_START_W[CW-1:0];
   localparam [`DSA_DIV_W-1:0] DIV_LAST = DIV_LAST_W[`DSA_DIV_W-1:0];
   localparam NSYNC = 4;

   // Reset release through two flops.
   reg rst_a_r, rst_n_r;
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_a_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_a_r <= 1'b1;
         rst_n_r <= rst_a_r;
      end
   end

   // Three-flop synchronisers; a change counts once stages two and three
   // agree, so a single metastable sample never flips a decision.
   wire [NSYNC-1:0] async_in = {hold_in, test_in, batt_low_in, comp_in};
   wire [NSYNC-1:0] sync_out;
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         reg s1_r, s2_r, s3_r, flt_r;
         always @(posedge ref_clk or negedge rst_n_r) begin
            if (!rst_n_r) begin
               s1_r  <= 1'b0;
               s2_r  <= 1'b0;
               s3_r  <= 1'b0;
               flt_r <= 1'b0;
            end else begin
               s1_r <= async_in[gi];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r)
                  flt_r <= s3_r;
            end
         end
         assign sync_out[gi] = flt_r;
      end
   endgenerate
   wire comp_s = sync_out[0];
   wire batt_s = sync_out[1];
   wire test_s = sync_out[2];
   wire hold_s = sync_out[3];

   // Divide by four; one count is four ref_clk cycles.
   reg [`DSA_DIV_W-1:0] div_r;
   wire tick = (div_r == DIV_LAST);

   // Sequencer state.
   reg [`DSA_PH_W-1:0] ph_r, ph_nxt;
   reg [CW-1:0] conv_r;   // Counts since conversion start.
   reg [CW-1:0] ph_cnt_r; // Counts within current phase.
   reg          pol_neg_r;
   reg [CW-1:0] res_r;
   reg          res_neg_r;
   reg          done;     // De-integration ends on this tick.

   // Phase decisions on each count tick.
   always @* begin
      ph_nxt = ph_r;
      done   = 1'b0;
      case (ph_r)
         `DSA_PH_AZ:
            if (conv_r == CONV_LAST)
               ph_nxt = `DSA_PH_INT;
         `DSA_PH_INT:
            if (ph_cnt_r == INT_LAST)
               ph_nxt = `DSA_PH_DEINT;
         `DSA_PH_DEINT: begin
            // Zero crossing: the comparator leaves the side it held when
            // integration ended.
            if ((comp_s != pol_neg_r) || (ph_cnt_r == DEI_LAST)) begin
               ph_nxt = `DSA_PH_AZ;
               done   = 1'b1;
            end
         end
         default: ph_nxt = `DSA_PH_AZ;
      endcase
   end

   // Counting and latching; the conversion counter wraps at its length so
   // auto-zero absorbs whatever de-integration left unused.
   always @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         div_r     <= {`DSA_DIV_W{1'b0}};
         ph_r      <= `DSA_PH_AZ;
         conv_r    <= AZ_START;
         ph_cnt_r  <= {CW{1'b0}};
         pol_neg_r <= 1'b0;
         res_r     <= {CW{1'b0}};
         res_neg_r <= 1'b0;
      end else begin
         div_r <= div_r + 1'b1;
         if (tick) begin
            ph_r     <= ph_nxt;
            conv_r   <= (conv_r == CONV_LAST) ? {CW{1'b0}} : conv_r + 1'b1;
            ph_cnt_r <= (ph_nxt != ph_r) ? {CW{1'b0}} : ph_cnt_r + 1'b1;
            if (ph_r == `DSA_PH_INT && ph_nxt == `DSA_PH_DEINT)
               pol_neg_r <= comp_s;
            if (done && !hold_s) begin
               res_r     <= ph_cnt_r;
               res_neg_r <= pol_neg_r;
            end
         end
      end
   end

   // Binary result to BCD by shift-and-add.
   function [15:0] to_bcd;
      input [CW-1:0] bin;
      integer i;
      reg [15:0] b;
      begin
         b = 16'h0000;
         for (i = CW - 1; i >= 0; i = i - 1) begin
            if (b[3:0]   > 4'h4) b[3:0]   = b[3:0]   + 4'h3;
            if (b[7:4]   > 4'h4) b[7:4]   = b[7:4]   + 4'h3;
            if (b[11:8]  > 4'h4) b[11:8]  = b[11:8]  + 4'h3;
            if (b[15:12] > 4'h4) b[15:12] = b[15:12] + 4'h3;
            b = {b[14:0], bin[i]};
         end
         to_bcd = b;
      end
   endfunction

   wire [15:0] bcd = to_bcd(res_r);
   wire [6:0]  u_dec, t_dec, h_dec;
   dsa_seg_dec u_units    (.digit(bcd[3:0]),  .seg(u_dec));
   dsa_seg_dec u_tens     (.digit(bcd[7:4]),  .seg(t_dec));
   dsa_seg_dec u_hundreds (.digit(bcd[11:8]), .seg(h_dec));

   // Registered outputs: switches, status and segments.
   always @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sw_in_to_com     <= 1'b0;
         sw_ref_charge    <= 1'b0;
         sw_az_loop       <= 1'b0;
         sw_in_connect    <= 1'b0;
         sw_lo_to_com     <= 1'b0;
         sw_ref_pos       <= 1'b0;
         sw_ref_neg       <= 1'b0;
         integ_status_out <= 1'b0;
         deint_status_out <= 1'b0;
         count_tick       <= 1'b0;
         units_seg        <= `DSA_SEG_OFF;
         tens_seg         <= `DSA_SEG_OFF;
         hundreds_seg     <= `DSA_SEG_OFF;
         thousands_bc_seg <= 1'b0;
         minus_sign_seg   <= 1'b0;
         low_batt_seg     <= 1'b0;
      end else begin
         sw_in_to_com     <= (ph_r == `DSA_PH_AZ);
         sw_ref_charge    <= (ph_r == `DSA_PH_AZ);
         sw_az_loop       <= (ph_r == `DSA_PH_AZ);
         sw_in_connect    <= (ph_r == `DSA_PH_INT);
         sw_lo_to_com     <= (ph_r == `DSA_PH_DEINT);
         // Reference orientation opposes the stored input sign.
         sw_ref_pos <= (ph_r == `DSA_PH_DEINT) && pol_neg_r;
         sw_ref_neg <= (ph_r == `DSA_PH_DEINT) && !pol_neg_r;
         integ_status_out <= (ph_r == `DSA_PH_INT);
         deint_status_out <= (ph_r == `DSA_PH_DEINT);
         count_tick       <= tick;
         low_batt_seg     <= batt_s;
         if (test_s) begin
            units_seg        <= `DSA_SEG_ALL;
            tens_seg         <= `DSA_SEG_ALL;
            hundreds_seg     <= `DSA_SEG_ALL;
            thousands_bc_seg <= 1'b1;
            minus_sign_seg   <= 1'b1;
         end else begin
            units_seg        <= u_dec;
            tens_seg         <= t_dec;
            hundreds_seg     <= h_dec;
            thousands_bc_seg <= (bcd[15:12] != 4'h0);
            minus_sign_seg   <= res_neg_r;
         end
      end
   end
endmodule

// ===== sim/dsa_seq_properties.sv
// Port checker for the converter sequencer.
// Assumes it is bound onto dsa_seq and shares its count parameters.
`timescale 1ns/1ns
module dsa_seq_props #(
   parameter INT_COUNTS  = 1000,
   parameter DEINT_MAX   = 2000,
   parameter CONV_COUNTS = 4000
) (
   // Watched ports, grouped to keep the list short.
   input wire       ref_clk, arst_n, test_in, hold_in, batt_low_in,
   input wire       sw_in_to_com, sw_ref_charge, sw_az_loop,
   input wire       sw_in_connect, sw_lo_to_com, sw_ref_pos, sw_ref_neg,
   input wire       integ_status_out, deint_status_out, count_tick,
   input wire       thousands_bc_seg, minus_sign_seg, low_batt_seg,
   input wire [6:0] units_seg, tens_seg, hundreds_seg
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   localparam int AZ_MAX = 4 * (CONV_COUNTS - INT_COUNTS);
   localparam int AZ_MIN = 4 * (CONV_COUNTS - INT_COUNTS - DEINT_MAX);
   reg [15:0] il_r, dl_r, pl_r, al_r;
   reg        seen_r;
   // Phase and period lengths in clocks; a period is judged only once a
   // full one has begun, since the first one after reset starts anywhere.
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         il_r   <= 16'h0;
         dl_r   <= 16'h0;
         pl_r   <= 16'h0;
         al_r   <= 16'h0;
         seen_r <= 1'b0;
      end else begin
         il_r   <= integ_status_out ? il_r + 16'h1 : 16'h0;
         al_r   <= sw_in_to_com ? al_r + 16'h1 : 16'h0;
         dl_r   <= deint_status_out ? dl_r + 16'h1 : 16'h0;
         pl_r   <= $rose(integ_status_out) ? 16'h1 : pl_r + 16'h1;
         seen_r <= seen_r | $rose(integ_status_out);
      end
   end
   property p_az;
      sw_in_to_com |-> sw_ref_charge && sw_az_loop && !sw_in_connect;
   endproperty
   a_az: assert property (p_az) else $error("auto-zero switches");
   property p_ilen;
      $fell(integ_status_out) |-> il_r == 4 * INT_COUNTS && deint_status_out;
   endproperty
   a_ilen: assert property (p_ilen) else $error("integrate length");
   property p_stat;
      integ_status_out == sw_in_connect
         && !(integ_status_out && deint_status_out);
   endproperty
   a_stat: assert property (p_stat) else $error("status outputs");
   property p_dsw;
      deint_status_out |-> sw_lo_to_com && (sw_ref_pos != sw_ref_neg);
   endproperty
   a_dsw: assert property (p_dsw) else $error("de-int switches");
   property p_pol;
      deint_status_out && $past(deint_status_out) |-> $stable(sw_ref_pos);
   endproperty
   a_pol: assert property (p_pol) else $error("polarity moved");
   property p_dmax;
      dl_r <= 4 * DEINT_MAX;
   endproperty
   a_dmax: assert property (p_dmax) else $error("de-int too long");
   // Auto-zero length in clocks, the first one after reset included.
   property p_azlen;
      $fell(sw_in_to_com) |-> al_r >= AZ_MIN && al_r <= AZ_MAX;
   endproperty
   a_azlen: assert property (p_azlen) else $error("auto-zero length");
   property p_per;
      $rose(integ_status_out) && seen_r |-> pl_r == 4 * CONV_COUNTS;
   endproperty
   a_per: assert property (p_per) else $error("conversion length");
   property p_tick;
      count_tick |=> !count_tick [*3] ##1 count_tick;
   endproperty
   a_tick: assert property (p_tick) else $error("count tick rate");
   property p_tst;
      test_in [*7] |-> minus_sign_seg && thousands_bc_seg
         && {units_seg, tens_seg, hundreds_seg} == 21'h1fffff;
   endproperty
   a_tst: assert property (p_tst) else $error("display test");
   property p_bat;
      batt_low_in [*7] |-> low_batt_seg;
   endproperty
   a_bat: assert property (p_bat) else $error("battery segment");
   property p_hld;
      (hold_in && !test_in) [*8] |-> $stable({units_seg, tens_seg,
         hundreds_seg, thousands_bc_seg, minus_sign_seg});
   endproperty
   a_hld: assert property (p_hld) else $error("hold let change");
endmodule
bind dsa_seq dsa_seq_props #(.INT_COUNTS(INT_COUNTS),
   .DEINT_MAX(DEINT_MAX), .CONV_COUNTS(CONV_COUNTS)) i_props (.*);

// ===== sim/dsa_afe_model.sv
// Integrator and comparator as seen through the sequencer's switches.
// Assumes one reference step per count equals INT_COUNTS input units.
`timescale 1ns/1ns
module dsa_afe_model #(
   parameter INT_COUNTS = 1000
) (
   // Switch drive and count pulse from the sequencer.
   input wire               ref_clk, count_tick, sw_in_to_com,
   input wire               sw_in_connect, sw_ref_pos, sw_ref_neg,
   // Input level in display counts, signed.
   input wire signed [15:0] vin,
   // High while the integrator sits on the negative side.
   output reg               comp_in = 1'b0
);
   integer acc = 0;
   integer acc_nxt;
   // Integrator value once the current clock closes.
   always @* begin
      acc_nxt = acc;
      if (sw_in_to_com)
         acc_nxt = 0;
      else if (count_tick && sw_in_connect)
         acc_nxt = acc + vin;
      else if (count_tick && (sw_ref_pos || sw_ref_neg))
         acc_nxt = acc + (sw_ref_pos ? INT_COUNTS : -INT_COUNTS);
   end
   // Zero counts as crossed while ramping down, so that an input of v
   // counts can return in v counts rather than always one late.
   always @(posedge ref_clk) begin
      acc     <= acc_nxt;
      comp_in <= (acc_nxt < 0) || (acc_nxt == 0 && sw_ref_neg);
   end
endmodule

// ===== sim/dsa_seq_tb_top.sv
// Self-checking bench for the converter sequencer at full counts.
// Assumes the front-end model and the bound checker are compiled too.
`timescale 1ns/1ns
module dsa_seq_tb_top;
   reg               ref_clk = 1'b0, arst_n = 1'b0, test_in = 1'b0;
   reg               hold_in = 1'b0, batt_low_in = 1'b0;
   reg signed [15:0] vin = 16'sh0;
   wire              comp_in, sw_in_to_com, sw_ref_charge, sw_az_loop;
   wire              sw_in_connect, sw_lo_to_com, sw_ref_pos, sw_ref_neg;
   wire              integ_status_out, deint_status_out, count_tick;
   wire              thousands_bc_seg, minus_sign_seg, low_batt_seg;
   wire [6:0]        units_seg, tens_seg, hundreds_seg;
   int               num_errors = 0, n_compared = 0;
   always #5 ref_clk = ~ref_clk;
   dsa_seq i_dut (.*);
   dsa_afe_model i_afe (.*);
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %0d seen %0d", nm, exp, seen);
      end
   endtask
   // Blank reads as zero; an unknown pattern gives a value that mismatches.
   function automatic int dig(input logic [6:0] s);
      case (s)
         7'h00, 7'h3f: dig = 0;
         7'h06: dig = 1;
         7'h5b: dig = 2;
         7'h4f: dig = 3;
         7'h66: dig = 4;
         7'h6d: dig = 5;
         7'h7d: dig = 6;
         7'h07: dig = 7;
         7'h7f: dig = 8;
         7'h6f: dig = 9;
         default: dig = 99;
      endcase
   endfunction
   // Waits for the next de-integration to end and the display to settle.
   task automatic to_deint_end();
      int n;
      n = 0;
      for (int k = 1; k >= 0; k--)
         while (deint_status_out !== k[0] && n < 40000) begin
            @(posedge ref_clk);
            #1 n++;
         end
      check("deint wait", n < 40000, 1);
      repeat (4) @(posedge ref_clk);
      #1;
   endtask
   task automatic scen_flags();
      test_in = 1'b1;
      repeat (8) @(posedge ref_clk);
      #1 check("test digits", {units_seg, tens_seg, hundreds_seg},
               21'h1fffff);
      check("test sign", {thousands_bc_seg, minus_sign_seg}, 2'h3);
      test_in = 1'b0;
      for (int b = 1; b >= 0; b--) begin
         batt_low_in = b[0];
         repeat (8) @(posedge ref_clk);
         #1 check("low battery", low_batt_seg, b[0]);
      end
   endtask
   // The comparator path may add up to two counts of delay.
   task automatic scen_read(input int v);
      int a, r;
      a = (v < 0) ? -v : v;
      vin = v[15:0];
      to_deint_end();
      r = dig(units_seg) + 10 * dig(tens_seg) + 100 * dig(hundreds_seg)
          + 1000 * thousands_bc_seg;
      check("reading", (r >= a && r <= a + 2) ? a : r, a);
      check("minus sign", minus_sign_seg, v < 0);
   endtask
   task automatic scen_hold();
      logic [22:0] was;
      was = {units_seg, tens_seg, hundreds_seg, thousands_bc_seg,
             minus_sign_seg};
      hold_in = 1'b1;
      vin = -16'sd50;
      to_deint_end();
      check("held display", {units_seg, tens_seg, hundreds_seg,
            thousands_bc_seg, minus_sign_seg}, was);
      hold_in = 1'b0;
   endtask
   task automatic final_report();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #800000 num_errors++;
      final_report();
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      #1 arst_n = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 scen_flags();
      to_deint_end();
      scen_read(1234);
      scen_hold();
      scen_read(-50);
      final_report();
   end
endmodule
